// ===== raf_filter.sv
// reading averaging filter: sliding or block average over 2..100 readings
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RQ1: average a programmable count of readings, count only accepted from 2 to 100
// RQ2: two modes, sliding-window average and block average
// RQ3: sliding mode keeps readings first-in first-out, new displaces oldest
// RQ4: sliding mode, first reading after start fills the whole stack
// RQ5: sliding mode, a fresh average for every new reading
// RQ6: block mode, output only once the stack holds the count of readings
// RQ7: block mode, empty the stack after each output and restart
// RQ8: diode, continuity, frequency and period readings pass unaveraged
// RQ9: after reset enabled, sliding mode, count ten
// RQ10: toggle input flips enable, indicator high exactly while enabled
// RQ11: count set to value, minimum or maximum, and readable back
// RQ12: any change of mode, count or enable flushes the stack
// RQ13: while disabled each reading passes unchanged with its valid strobe
////////////////////////////////////////////////////////////////////////////////
module raf_filter #(
  parameter int unsigned DATA_W = raf_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // register bus
  input  wire raf_pkg::raf_apb_req_s apbReq,
  output var  raf_pkg::raf_apb_rsp_s apbRsp,
  // readings in
  input  wire logic                 rdValid,
  input  wire logic [DATA_W-1:0]    rdData,
  output var  logic                 rdReady,
  // averaged readings out
  output var  logic                 avgValid,
  output var  logic [DATA_W-1:0]    avgData,
  // front panel
  input  wire logic                 filterToggle,
  output var  logic                 averagingActiveIndicator
);
  import raf_pkg::*;

  localparam int SUM_W   = DATA_W + CNT_W;
  localparam int OUT_LAT = SUM_W + 1;
  localparam int BIT_W   = 6;

  if (DATA_W < 8 || DATA_W > 32) begin : g_width_check
    $error("raf_filter: DATA_W must be 8 to 32");
  end

  function automatic logic countLegal(input logic [7:0] v);
    return (v >= 8'(MIN_COUNT)) && (v <= 8'(MAX_COUNT));
  endfunction : countLegal

  function automatic logic bypassFn(input logic [FUNC_W-1:0] f);
    return (f == FN_DIODE) || (f == FN_CONT) || (f == FN_FREQ) || (f == FN_PERIOD);
  endfunction : bypassFn

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic                     enableReg;
  logic                     enableNext;
  raf_mode_e                modeReg;
  raf_mode_e                modeNext;
  logic [FUNC_W-1:0]        funcReg;
  logic [FUNC_W-1:0]        funcNext;
  logic [CNT_W-1:0]         countReg;
  logic [CNT_W-1:0]         countNext;
  raf_state_e               stateReg;
  raf_state_e               stateNext;
  logic signed [SUM_W-1:0]  sumReg;
  logic [CNT_W-1:0]         fillReg;
  logic [CNT_W-1:0]         wrPtrReg;
  logic [CNT_W-1:0]         fillIdxReg;
  logic signed [DATA_W-1:0] fillValReg;
  logic [SUM_W-1:0]         quoReg;
  logic [CNT_W:0]           remReg;
  logic [BIT_W-1:0]         bitCntReg;
  logic                     negReg;
  logic                     rdReadyReg;
  logic                     avgValidReg;
  logic [DATA_W-1:0]        avgDataReg;
  logic                     preadyReg;
  logic                     pslverrReg;
  logic [31:0]              prdataReg;
  logic signed [DATA_W-1:0] memArr [MAX_COUNT];

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        setup     = apbReq.psel & ~apbReq.penable;
  wire        access    = apbReq.psel & apbReq.penable & preadyReg;
  wire        selCtrl   = apbReq.paddr == CTRL_OFS;
  wire        selCount  = apbReq.paddr == COUNT_OFS;
  wire        selStatus = apbReq.paddr == STATUS_OFS;
  wire        mapped    = selCtrl | selCount | selStatus;
  wire [31:0] wd        = apbReq.pwdata;
  wire        cntMinMax = wd[COUNT_MIN_BIT] | wd[COUNT_MAX_BIT];
  wire        cntBad    = selCount & apbReq.pwrite & ~cntMinMax & ~countLegal(wd[7:0]); // RQ1
  wire        errNext   = ~mapped | (selStatus & apbReq.pwrite) | cntBad;
  wire        wrOk      = access & apbReq.pwrite & ~pslverrReg;
  wire        wrCtrl    = wrOk & selCtrl;
  wire        wrCount   = wrOk & selCount;

  // limits take precedence over the value field
  wire [CNT_W-1:0] cntReqVal = wd[COUNT_MAX_BIT] ? CNT_W'(MAX_COUNT) :
                               wd[COUNT_MIN_BIT] ? CNT_W'(MIN_COUNT) : wd[CNT_W-1:0]; // RQ11

  //////////////////////////////////////////////////////////////////////////////
  // configuration
  assign enableNext = (wrCtrl ? wd[CTRL_EN_BIT] : enableReg) ^ filterToggle; // RQ10
  assign modeNext   = wrCtrl ? raf_mode_e'(wd[CTRL_MODE_BIT]) : modeReg; // RQ2
  assign funcNext   = wrCtrl ? wd[CTRL_FUNC_LSB +: FUNC_W] : funcReg;
  assign countNext  = wrCount ? cntReqVal : countReg;

  wire flush = (enableNext != enableReg) | (modeNext != modeReg) |
               (countNext != countReg) | (funcNext != funcReg); // RQ12
  wire active = enableReg & ~bypassFn(funcReg); // RQ8

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enableReg <= RST_ENABLE; // RQ9
      modeReg   <= RAF_SLIDING;
      funcReg   <= RST_FUNC;
      countReg  <= RST_COUNT;
    end else begin
      enableReg <= enableNext;
      modeReg   <= modeNext;
      funcReg   <= funcNext;
      countReg  <= countNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait-free access phase after each setup
  wire [31:0] statusWord = {17'h0, fillReg, 5'h0, active, stateReg != ST_IDLE, enableReg};
  wire [31:0] ctrlWord   = {24'h0, funcReg, 2'h0, modeReg, enableReg};
  wire [31:0] rdMux      = selCtrl   ? ctrlWord :
                           selCount  ? {25'h0, countReg} : // RQ11
                           selStatus ? statusWord : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= 32'h0;
    end else begin
      preadyReg  <= setup;
      pslverrReg <= setup & errNext;
      prdataReg  <= (setup & ~apbReq.pwrite & mapped) ? rdMux : 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stack datapath
  wire signed [DATA_W-1:0] x       = rdData;
  wire signed [DATA_W-1:0] oldest  = memArr[wrPtrReg];
  wire                     accept  = rdValid & rdReadyReg & (stateReg == ST_IDLE) & ~flush;
  wire                     doSlide = accept & active & (modeReg == RAF_SLIDING);
  wire                     doBlock = accept & active & (modeReg == RAF_BLOCK);
  wire                     firstRd = doSlide & (fillReg == '0);
  wire                     slideSt = doSlide & (fillReg != '0);
  wire                     blkLast = doBlock & (fillReg + 7'h01 == countReg);
  wire                     inFill  = stateReg == ST_FILL;
  wire                     fillEnd = inFill & (fillIdxReg + 7'h01 == countReg);
  wire [CNT_W-1:0]         ptrWrap = (wrPtrReg + 7'h01 == countReg) ? '0 : wrPtrReg + 7'h01;

  wire signed [SUM_W-1:0] sumSlide = sumReg + SUM_W'(x) - SUM_W'(oldest); // RQ3
  wire signed [SUM_W-1:0] sumBlock = sumReg + SUM_W'(x);
  wire signed [SUM_W-1:0] sumFill  = sumReg + SUM_W'(fillValReg);
  wire signed [SUM_W-1:0] divVal   = inFill ? sumFill : slideSt ? sumSlide : sumBlock;
  wire                    divStart = (fillEnd | slideSt | blkLast) & ~flush;
  wire [SUM_W-1:0]        divAbs   = divVal[SUM_W-1] ? SUM_W'(-divVal) : SUM_W'(divVal);

  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE: begin
        if (firstRd) begin
          stateNext = ST_FILL; // RQ4
        end else if (slideSt | blkLast) begin
          stateNext = ST_DIV; // RQ5 RQ6
        end
      end
      ST_FILL: begin
        if (fillEnd) begin
          stateNext = ST_DIV;
        end
      end
      ST_DIV: begin
        if (bitCntReg == BIT_W'(SUM_W - 1)) begin
          stateNext = ST_IDLE;
        end
      end
    endcase
    if (flush) begin
      stateNext = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateReg   <= ST_IDLE;
      rdReadyReg <= 1'b0;
    end else begin
      stateReg   <= stateNext;
      rdReadyReg <= stateNext == ST_IDLE;
    end
  end

  // stack memory: fill writes the first reading into entries 0 to countReg-1
  wire                     memWe   = (inFill & ~flush) | slideSt;
  wire [CNT_W-1:0]         memAddr = inFill ? fillIdxReg : wrPtrReg;
  wire signed [DATA_W-1:0] memDin  = inFill ? fillValReg : x;

  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      memArr[memAddr] <= memDin; // RQ3 RQ4
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || flush) begin
      sumReg     <= '0; // RQ12
      fillReg    <= '0;
      wrPtrReg   <= '0;
      fillIdxReg <= '0;
      fillValReg <= '0;
    end else if (firstRd) begin
      fillValReg <= x;
      fillIdxReg <= '0;
      sumReg     <= '0;
    end else if (inFill) begin
      sumReg     <= sumFill;
      fillIdxReg <= fillIdxReg + 7'h01;
      fillReg    <= fillEnd ? countReg : fillReg;
      wrPtrReg   <= '0;
    end else if (slideSt) begin
      sumReg   <= sumSlide; // RQ3
      wrPtrReg <= ptrWrap;
    end else if (blkLast) begin
      sumReg  <= '0; // RQ7
      fillReg <= '0;
    end else if (doBlock) begin
      sumReg  <= sumBlock; // RQ6
      fillReg <= fillReg + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // restoring divider: one quotient bit per cycle
  wire [CNT_W:0]     remShift = {remReg[CNT_W-1:0], quoReg[SUM_W-1]};
  wire               remGe    = remShift >= {1'b0, countReg};
  wire [CNT_W:0]     remNew   = remGe ? remShift - {1'b0, countReg} : remShift;
  wire [SUM_W-1:0]   quoNew   = {quoReg[SUM_W-2:0], remGe};
  wire [DATA_W-1:0]  quoLow   = quoNew[DATA_W-1:0];
  wire [DATA_W-1:0]  avgRes   = negReg ? DATA_W'(-quoLow) : quoLow;
  wire               divLast  = (stateReg == ST_DIV) & (bitCntReg == BIT_W'(SUM_W - 1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      quoReg    <= '0;
      remReg    <= '0;
      bitCntReg <= '0;
      negReg    <= 1'b0;
    end else if (divStart) begin
      quoReg    <= divAbs;
      remReg    <= '0;
      bitCntReg <= '0;
      negReg    <= divVal[SUM_W-1];
    end else if (stateReg == ST_DIV) begin
      quoReg    <= quoNew;
      remReg    <= remNew;
      bitCntReg <= bitCntReg + BIT_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      avgValidReg <= 1'b0;
      avgDataReg  <= '0;
    end else if (!active) begin
      avgValidReg <= rdValid; // RQ8 RQ13
      avgDataReg  <= rdData;
    end else if (divLast && !flush) begin
      avgValidReg <= 1'b1; // RQ5 RQ6
      avgDataReg  <= avgRes;
    end else begin
      avgValidReg <= 1'b0;
    end
  end

  assign apbRsp.pready            = preadyReg;
  assign apbRsp.pslverr           = pslverrReg;
  assign apbRsp.prdata            = prdataReg;
  assign rdReady                  = rdReadyReg;
  assign avgValid                 = avgValidReg;
  assign avgData                  = avgDataReg;
  assign averagingActiveIndicator = enableReg; // RQ10

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  count_range_a: assert property ( // RQ1
    countLegal({1'b0, countReg}))
    else $error("count left the 2 to 100 range");

  mode_legal_a: assert property ( // RQ2
    wrCtrl |=> modeReg == raf_mode_e'($past(wd[CTRL_MODE_BIT])))
    else $error("mode write not applied");

  reset_defaults_a: assert property ( // RQ9
    $past(sys_rst) |-> enableReg && modeReg == RAF_SLIDING && countReg == 7'h0a)
    else $error("wrong configuration after reset");

  toggle_flips_a: assert property ( // RQ10
    filterToggle && !wrCtrl |=> enableReg != $past(enableReg)
      && averagingActiveIndicator == enableReg)
    else $error("toggle did not flip enable");

  bypass_pass_a: assert property ( // RQ13
    !active && rdValid |=> avgValid && avgData == $past(rdData))
    else $error("bypassed reading not forwarded");

  fill_done_a: assert property ( // RQ4
    fillEnd && !flush |=> stateReg == ST_DIV && fillReg == $past(countReg))
    else $error("stack fill did not complete");

  slide_fifo_a: assert property ( // RQ3
    slideSt |=> memArr[$past(wrPtrReg)] == $past(x) && sumReg == $past(sumSlide))
    else $error("oldest reading not displaced");

  slide_every_a: assert property ( // RQ5
    disable iff (sys_rst || flush)
    slideSt |-> ##OUT_LAT avgValid)
    else $error("no average for a new reading");

  block_wait_a: assert property ( // RQ6
    doBlock && !blkLast |=> !avgValid && fillReg == $past(fillReg) + 7'h01 ##1 !avgValid)
    else $error("block output before stack full");

  block_flush_a: assert property ( // RQ7
    blkLast |=> fillReg == '0 && sumReg == '0 && stateReg == ST_DIV)
    else $error("block stack not emptied");

  function_bypass_a: assert property ( // RQ8
    bypassFn(funcReg) |-> stateReg == ST_IDLE || $past(flush))
    else $error("averaging while function excludes it");

  count_limits_a: assert property ( // RQ11
    wrCount && wd[COUNT_MAX_BIT] |=> countReg == 7'h64)
    else $error("maximum count not applied");

  flush_clears_a: assert property ( // RQ12
    flush |=> fillReg == '0 && stateReg == ST_IDLE && (!avgValid || !$past(active)))
    else $error("stack not flushed on change");

endmodule : raf_filter

// ===== raf_pkg.sv
// shared constants and types for the reading averaging filter
package raf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and limits
  localparam int unsigned DATA_W    = 24;
  localparam int unsigned CNT_W     = 7;
  localparam int unsigned FUNC_W    = 4;
  localparam int unsigned MIN_COUNT = 2;
  localparam int unsigned MAX_COUNT = 100;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] COUNT_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // field positions
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_MODE_BIT   = 1;
  localparam int unsigned CTRL_FUNC_LSB   = 4;
  localparam int unsigned COUNT_MIN_BIT   = 8;
  localparam int unsigned COUNT_MAX_BIT   = 9;
  localparam int unsigned STAT_EN_BIT     = 0;
  localparam int unsigned STAT_BUSY_BIT   = 1;
  localparam int unsigned STAT_ACT_BIT    = 2;
  localparam int unsigned STAT_FILL_LSB   = 8;

  // values after reset
  localparam logic             RST_ENABLE = 1'b1;
  localparam logic [CNT_W-1:0] RST_COUNT  = 7'h0a;
  localparam logic [FUNC_W-1:0] RST_FUNC  = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // measurement functions that the filter must not average
  localparam logic [FUNC_W-1:0] FN_DIODE  = 4'h5;
  localparam logic [FUNC_W-1:0] FN_CONT   = 4'h6;
  localparam logic [FUNC_W-1:0] FN_FREQ   = 4'h7;
  localparam logic [FUNC_W-1:0] FN_PERIOD = 4'h8;

  typedef enum logic {
    RAF_SLIDING = 1'b0,
    RAF_BLOCK   = 1'b1
  } raf_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_DIV  = 3'b100
  } raf_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } raf_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } raf_apb_rsp_s;

endpackage : raf_pkg

// ===== raf_reading_source.sv
// partner model: measurement converter offering readings to the filter
`timescale 1ns/100ps
module raf_reading_source (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  // bench request
  input  wire logic                       sendReq,
  input  wire logic [raf_pkg::DATA_W-1:0] sendData,
  input  wire logic                       slow,
  output var  logic                       pending,
  // reading stream
  input  wire logic                       rdReady,
  output var  logic                       rdValid,
  output var  logic [raf_pkg::DATA_W-1:0] rdData
);
  import raf_pkg::*;

  logic [DATA_W-1:0] holdData;
  logic [1:0]        waitCnt;

  ////////////////////////////////////////////////////////////////////////////////
  // data line toggles whenever no reading is offered, so stale values never match
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdValid  <= 1'b0;
      pending  <= 1'b0;
      waitCnt  <= 2'h0;
      holdData <= '0;
      rdData   <= '0;
    end else if (sendReq) begin
      pending  <= 1'b1;
      holdData <= sendData;
      waitCnt  <= slow ? 2'h3 : 2'h0;
      rdData   <= ~rdData;
    end else if (rdValid) begin
      if (rdReady) begin
        rdValid <= 1'b0;
        pending <= 1'b0;
        rdData  <= ~rdData;
      end
    end else if (pending && waitCnt == 2'h0) begin
      rdValid <= 1'b1;
      rdData  <= holdData;
    end else begin
      waitCnt <= (waitCnt != 2'h0) ? waitCnt - 2'h1 : 2'h0;
      rdData  <= ~rdData;
    end
  end
endmodule : raf_reading_source

// ===== tb_reading_averaging_filter.sv
// self-checking testbench for the reading averaging filter
`timescale 1ns/100ps
module tb_reading_averaging_filter;
  import raf_pkg::*;

  logic                     ref_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  raf_apb_req_s             apbReq = '0;
  raf_apb_rsp_s             apbRsp;
  logic                     rdValid, rdReady, avgValid, indicator, pending;
  logic                     filterToggle = 1'b0, sendReq = 1'b0, slow = 1'b0;
  logic [DATA_W-1:0]        rdData, avgData, sendData = '0;
  logic [31:0]              rd;
  logic                     err;
  int                       failCount = 0, totalChecks = 0, cycles = 0, seed = 24, cnt;
  int                       curCount = 10;
  logic                     curMode = 1'b0, enabled = 1'b1;
  logic [3:0]               curFunc = 4'h0;
  logic signed [DATA_W-1:0] stack[$];
  logic [DATA_W-1:0]        outQ[$];
  logic [3:0]               fns[4] = '{FN_DIODE, FN_CONT, FN_FREQ, FN_PERIOD};
  logic [31:0]              wv[8] = '{32'h100, 32'h200, 32'h300, 32'h2, 32'h64, 32'h1,
                                      32'h65, 32'h0};
  int                       ev[8] = '{2, 100, 100, 2, 100, 100, 100, 100};

  raf_filter dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady), .avgValid(avgValid),
    .avgData(avgData), .filterToggle(filterToggle), .averagingActiveIndicator(indicator));
  raf_reading_source src (.ref_clk(ref_clk), .sys_rst(sys_rst), .sendReq(sendReq),
    .sendData(sendData), .slow(slow), .pending(pending), .rdReady(rdReady),
    .rdValid(rdValid), .rdData(rdData));

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (avgValid === 1'b1) outQ.push_back(avgData);
    if (cycles == 20000) begin
      failCount++;
      reportAndStop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(logic wr, logic [7:0] addr, logic [31:0] wd);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb

  function automatic logic [DATA_W-1:0] avgOf();
    longint s;
    s = 0;
    foreach (stack[i]) s += stack[i];
    return DATA_W'(s / stack.size());
  endfunction : avgOf

  task automatic setCfg(logic md, int c, logic [3:0] fn);
    apb(1'b1, CTRL_OFS, {24'h0, fn, 2'b0, md, 1'b1});
    check("ctrlErr", 32'(err), 32'h0);
    apb(1'b1, COUNT_OFS, 32'(c));
    check("countErr", 32'(err), 32'h0);
    curMode = md;
    curCount = c;
    curFunc = fn;
    enabled = 1'b1;
    stack.delete();
  endtask : setCfg

  task automatic feed(logic [DATA_W-1:0] d);
    logic              expOut;
    logic [DATA_W-1:0] exp;
    int                n;
    expOut = 1'b1;
    exp = d;
    if (enabled && !(curFunc inside {FN_DIODE, FN_CONT, FN_FREQ, FN_PERIOD})) begin
      if (curMode == RAF_SLIDING) begin
        if (stack.size() == 0) repeat (curCount) stack.push_back(d);
        else begin
          stack.push_back(d);
          void'(stack.pop_front());
        end
        exp = avgOf();
      end else begin
        stack.push_back(d);
        expOut = (stack.size() == curCount);
        if (expOut) begin
          exp = avgOf();
          stack.delete();
        end
      end
    end
    @(posedge ref_clk);
    sendReq <= 1'b1;
    sendData <= d;
    slow <= 1'($random(seed));
    @(posedge ref_clk);
    sendReq <= 1'b0;
    do begin
      @(posedge ref_clk);
    end while (pending === 1'b1);
    n = 0;
    while (outQ.size() == 0 && n < (expOut ? 300 : 40)) begin
      @(posedge ref_clk);
      n++;
    end
    check("avgCount", 32'(outQ.size()), 32'(expOut));
    if (expOut && outQ.size() != 0) check("avgData", 32'(outQ.pop_front()), 32'(exp));
    check("rdReady", 32'(rdReady), 32'h1);
  endtask : feed

  task automatic toggle();
    @(posedge ref_clk);
    filterToggle <= 1'b1;
    @(posedge ref_clk);
    filterToggle <= 1'b0;
    repeat (2) @(posedge ref_clk);
    enabled = ~enabled;
    stack.delete();
    check("indicator", 32'(indicator), 32'(enabled));
  endtask : toggle

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : reportAndStop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check("indicatorRst", 32'(indicator), 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrlRst", rd & 32'hf3, 32'h1);
    apb(1'b0, COUNT_OFS, 32'h0);
    check("countRst", rd & 32'h7f, 32'ha);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmappedErr", 32'(err), 32'h1);
    repeat (3) feed(DATA_W'($random(seed)));
    foreach (wv[k]) begin
      apb(1'b1, COUNT_OFS, wv[k]);
      check("countWrErr", 32'(err), 32'(k >= 5));
      apb(1'b0, COUNT_OFS, 32'h0);
      check("countRd", rd & 32'h7f, 32'(ev[k]));
      curCount = ev[k];
      if (k < 5) stack.delete();
    end
    repeat (2) feed(DATA_W'($random(seed)));
    for (int k = 0; k < 4; k++) begin
      cnt = (k < 2) ? 2 + ($unsigned($random(seed)) % 9) : 2;
      setCfg(k[0], cnt, 4'h0);
      repeat (k[0] ? 2 * cnt + 1 : 4) feed(DATA_W'($random(seed)));
    end
    foreach (fns[i]) begin
      setCfg(1'b0, 3, fns[i]);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("statusByp", rd & 32'h7, 32'h1);
      repeat (2) feed(DATA_W'($random(seed)));
    end
    setCfg(1'b0, 3, 4'h1);
    repeat (3) feed(DATA_W'($random(seed)));
    apb(1'b0, STATUS_OFS, 32'h0);
    check("statusFill", rd & 32'h7f07, 32'h0305);
    toggle();
    repeat (3) feed(DATA_W'($random(seed)));
    toggle();
    repeat (2) feed(DATA_W'($random(seed)));
    reportAndStop();
  end
endmodule : tb_reading_averaging_filter
